// ### rtl/spcg_pkg.sv
// How it works
// R1 - One enable bit per port, A at 0, E at 4
// R2 - Enabled port keeps its clock during Sleep
// R3 - Disabled port loses its clock during Sleep
// R4 - Access to gated port answers with bus fault
// R5 - Reset clears the whole register to zero
// R6 - Software preserves reserved bits on read-modify-write
// R7 - Software enables the ports it needs
// R8 - Run, Sleep, Deep-Sleep sets apply per mode
// R9 - Sleep sets used only with auto gating selected
// R10 - Reserved bits read zero; low bits read back
// R11 - Enables switch on Sleep entry and wake-up
package spcg_pkg;
   localparam int PORT_COUNT = 5;
   localparam logic [11:0] RUN_GATE_ADDR = 12'h108;
   localparam logic [11:0] SLEEP_GATE_ADDR = 12'h118;
   localparam logic [11:0] DEEP_GATE_ADDR = 12'h128;
   localparam logic [11:0] CLOCK_CONFIG_ADDR = 12'h060;
   localparam logic [11:0] MODE_ADDR = 12'h200;
   localparam int AUTO_GATE_BIT = 27;
   localparam logic [4:0] GATE_RESET = 5'h00;
   localparam logic [31:0] CONFIG_RESET = 32'h00000000;
   localparam logic [31:0] READ_ZERO = 32'h00000000;

   typedef enum logic [1:0] {
      SPCG_MODE_RUN = 2'b00,
      SPCG_MODE_SLEEP = 2'b01,
      SPCG_MODE_DEEP = 2'b10
   } spcg_mode_type;
endpackage : spcg_pkg

// ### rtl/spcg_gate_select.sv
`timescale 1ns/100ps
// Picks the clock enable set that belongs to the present power mode
module spcg_gate_select (
   // Gate sets
   input wire logic [4:0] run_set,
   input wire logic [4:0] sleep_set,
   input wire logic [4:0] deep_set,
   // Mode
   input wire logic auto_clock_gate_select,
   input wire spcg_pkg::spcg_mode_type mode,
   // Result
   output logic [4:0] enables
);
   always_comb begin
      enables = run_set;
      if (auto_clock_gate_select) begin // [R9]
         case (mode) // [R8] [R11]
            spcg_pkg::SPCG_MODE_RUN: begin
               enables = run_set;
            end
            spcg_pkg::SPCG_MODE_SLEEP: begin
               enables = sleep_set; // [R2] [R3]
            end
            spcg_pkg::SPCG_MODE_DEEP: begin
               enables = deep_set;
            end
            default: begin
               enables = run_set;
            end
         endcase
      end
   end
endmodule : spcg_gate_select

// ### rtl/spcg_top.sv
`timescale 1ns/100ps
// Port clock gating control with APB registers and a port access checker
module spcg_top (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Power mode request from the system
   input wire logic sleep_request,
   input wire logic deep_sleep_request,
   // Port access check from the system bus
   input wire logic port_access_valid,
   input wire logic [2:0] port_access_index,
   // Port clock enables, fault and power mode
   output logic port_a_clock_on,
   output logic port_b_clock_on,
   output logic port_c_clock_on,
   output logic port_d_clock_on,
   output logic port_e_clock_on,
   output logic port_bus_fault,
   output logic [1:0] power_mode
);
   typedef struct packed {
      logic [4:0] run_port_clock_gate;
      logic [4:0] sleep_port_clock_gate;
      logic [4:0] deep_sleep_port_clock_gate;
      logic [31:0] run_clock_config;
      spcg_pkg::spcg_mode_type mode;
      logic [4:0] enables;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      logic fault;
   } spcg_state_type;

   spcg_state_type state_reg;
   spcg_state_type state_next;
   logic [4:0] enables_sel;
   spcg_pkg::spcg_mode_type mode_sel;

   function automatic logic [31:0] spcg_widen(input logic [4:0] bits);
      spcg_widen = {27'h0000000, bits}; // [R10]
   endfunction : spcg_widen

   // Deep sleep wins over sleep; no request means run
   function automatic spcg_pkg::spcg_mode_type spcg_mode_of(input logic deep, input logic sleep);
      if (deep) begin
         spcg_mode_of = spcg_pkg::SPCG_MODE_DEEP;
      end else if (sleep) begin
         spcg_mode_of = spcg_pkg::SPCG_MODE_SLEEP;
      end else begin
         spcg_mode_of = spcg_pkg::SPCG_MODE_RUN;
      end
   endfunction : spcg_mode_of

   // Decoded from the pins, not from state_next, so the selector adds no loop through the next-state process
   assign mode_sel = spcg_mode_of(deep_sleep_request, sleep_request); // [R11]

   spcg_gate_select u_select (
      .run_set(state_reg.run_port_clock_gate),
      .sleep_set(state_reg.sleep_port_clock_gate),
      .deep_set(state_reg.deep_sleep_port_clock_gate),
      .auto_clock_gate_select(state_reg.run_clock_config[spcg_pkg::AUTO_GATE_BIT]),
      .mode(mode_sel),
      .enables(enables_sel)
   );

   always_comb begin
      state_next = state_reg;
      state_next.ready = 1'b0;
      state_next.slverr = 1'b0;
      state_next.fault = 1'b0;
      state_next.mode = mode_sel; // [R11]
      // Access phase: pready rises in the cycle after the first access cycle
      if (psel && penable && !state_reg.ready) begin
         state_next.ready = 1'b1;
         state_next.rdata = spcg_pkg::READ_ZERO;
         if (pwrite) begin
            case (paddr)
               spcg_pkg::RUN_GATE_ADDR: begin
                  state_next.run_port_clock_gate = pwdata[4:0];
               end
               spcg_pkg::SLEEP_GATE_ADDR: begin
                  state_next.sleep_port_clock_gate = pwdata[4:0]; // [R1] [R10]
               end
               spcg_pkg::DEEP_GATE_ADDR: begin
                  state_next.deep_sleep_port_clock_gate = pwdata[4:0];
               end
               spcg_pkg::CLOCK_CONFIG_ADDR: begin
                  state_next.run_clock_config = pwdata;
               end
               spcg_pkg::MODE_ADDR: begin
                  state_next.slverr = 1'b1;
               end
               default: begin
                  state_next.slverr = 1'b1;
               end
            endcase
         end else begin
            case (paddr)
               spcg_pkg::RUN_GATE_ADDR: begin
                  state_next.rdata = spcg_widen(state_reg.run_port_clock_gate);
               end
               spcg_pkg::SLEEP_GATE_ADDR: begin
                  state_next.rdata = spcg_widen(state_reg.sleep_port_clock_gate); // [R10]
               end
               spcg_pkg::DEEP_GATE_ADDR: begin
                  state_next.rdata = spcg_widen(state_reg.deep_sleep_port_clock_gate);
               end
               spcg_pkg::CLOCK_CONFIG_ADDR: begin
                  state_next.rdata = state_reg.run_clock_config;
               end
               spcg_pkg::MODE_ADDR: begin
                  state_next.rdata = {30'h00000000, state_reg.mode};
               end
               default: begin
                  state_next.slverr = 1'b1;
               end
            endcase
         end
      end
      state_next.enables = enables_sel; // [R2] [R3] [R8]
      // Access to a port whose clock is off, or to no port, faults
      if (port_access_valid) begin
         if (port_access_index >= 3'(spcg_pkg::PORT_COUNT)) begin
            state_next.fault = 1'b1;
         end else begin
            state_next.fault = !state_reg.enables[port_access_index]; // [R4]
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.run_port_clock_gate <= spcg_pkg::GATE_RESET;
         state_reg.sleep_port_clock_gate <= spcg_pkg::GATE_RESET; // [R5]
         state_reg.deep_sleep_port_clock_gate <= spcg_pkg::GATE_RESET;
         state_reg.run_clock_config <= spcg_pkg::CONFIG_RESET;
         state_reg.mode <= spcg_pkg::SPCG_MODE_RUN;
         state_reg.enables <= spcg_pkg::GATE_RESET;
         state_reg.rdata <= spcg_pkg::READ_ZERO;
         state_reg.ready <= 1'b0;
         state_reg.slverr <= 1'b0;
         state_reg.fault <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign prdata = state_reg.rdata;
   assign pready = state_reg.ready;
   assign pslverr = state_reg.slverr;
   assign port_a_clock_on = state_reg.enables[0];
   assign port_b_clock_on = state_reg.enables[1];
   assign port_c_clock_on = state_reg.enables[2];
   assign port_d_clock_on = state_reg.enables[3];
   assign port_e_clock_on = state_reg.enables[4];
   assign port_bus_fault = state_reg.fault;
   assign power_mode = state_reg.mode;
endmodule : spcg_top

// ### test/spcg_checker.sv
`timescale 1ns/100ps
module spcg_checker (
   // Watched ports
   input wire logic pclk, presetn, psel, penable, pready, pslverr, sleep_request, deep_sleep_request,
   input wire logic port_access_valid, port_a_clock_on, port_e_clock_on, port_bus_fault,
   input wire logic [2:0] port_access_index,
   input wire logic [1:0] power_mode
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("ready late");
   property p_off; port_access_valid && port_access_index == 3'h0 && !port_a_clock_on |=> port_bus_fault; endproperty
   a_off: assert property (p_off) else $error("no fault");
   property p_on; port_access_valid && port_access_index == 3'h4 && port_e_clock_on |=> !port_bus_fault; endproperty
   a_on: assert property (p_on) else $error("false fault");
   property p_none; port_access_valid && port_access_index > 3'h4 |=> port_bus_fault; endproperty
   a_none: assert property (p_none) else $error("no fault");
   property p_deep; deep_sleep_request |=> power_mode == 2'h2; endproperty
   a_deep: assert property (p_deep) else $error("mode");
   property p_sleep; sleep_request && !deep_sleep_request |=> power_mode == 2'h1; endproperty
   a_sleep: assert property (p_sleep) else $error("mode");
   property p_run; !sleep_request && !deep_sleep_request |=> power_mode == 2'h0; endproperty
   a_run: assert property (p_run) else $error("mode");
   property p_reset; $rose(presetn) |-> !port_a_clock_on && !port_e_clock_on; endproperty
   a_reset: assert property (p_reset) else $error("clock on");
   cover property (port_bus_fault);
   cover property (pready && pslverr);
   cover property (power_mode == 2'h1 && port_a_clock_on);
endmodule : spcg_checker
bind spcg_top spcg_checker spcg_checker_i (.*);

// ### test/tb.sv
`timescale 1ns/100ps
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, port_bus_fault;
   logic sleep_request = 0, deep_sleep_request = 0, port_access_valid = 0;
   logic port_a_clock_on, port_b_clock_on, port_c_clock_on, port_d_clock_on, port_e_clock_on;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic [2:0] port_access_index = 3'h0;
   logic [1:0] power_mode;
   wire [4:0] clocks_on = {port_e_clock_on, port_d_clock_on, port_c_clock_on, port_b_clock_on, port_a_clock_on};
   logic [4:0] ex, sl, rn, dp;
   logic [33:0] e, q[$];
   int fail_count = 0, comparisons = 0, seed = 32'hf3ef, k, m, i;
   spcg_top spcg_top_i (.*);
   initial forever #50 pclk = ~pclk;
   task chk(input string n, input logic [32:0] s, x);
      comparisons++;
      if (s !== x) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask : chk
   task conclude;
      if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [33:0] x);
      int t;
      q.push_back(x);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk) penable <= 1;
      t = 0;
      do begin
         @(posedge pclk);
         t++;
      end while (pready !== 1'b1 && t < 20);
      if (t == 20) begin
         fail_count++;
         conclude;
      end
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask : apb
   // Result watcher: takes the oldest note at each answer
   always @(posedge pclk) if (pready === 1'b1) begin
      e = q.pop_front();
      chk("apb", {pslverr, e[33] ? prdata : 32'h0}, e[32:0]);
   end
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, 12'h118, 32'h0, {2'h2, 32'h0});
      apb(0, 12'h204, 32'h0, {2'h3, 32'h0});
      r = $random(seed);
      sl = r[4:0];
      apb(1, 12'h118, r, 34'h0);
      apb(0, 12'h118, 32'h0, {2'h2, 27'h0, sl});
      apb(1, 12'h118, {27'h0, sl}, 34'h0);
      apb(1, 12'h200, r, {2'h1, 32'h0});
      r = $random(seed);
      rn = r[4:0];
      apb(1, 12'h108, r, 34'h0);
      r = $random(seed);
      dp = r[4:0];
      apb(1, 12'h128, r, 34'h0);
      for (k = 0; k < 2; k++) for (m = 0; m < 3; m++) begin
         if (m == 0) apb(1, 12'h060, {4'h0, k[0], 27'h0}, 34'h0);
         sleep_request <= m == 1;
         deep_sleep_request <= m == 2;
         repeat (3) @(posedge pclk);
         ex = k && m == 1 ? sl : k && m == 2 ? dp : rn;
         chk("enables", clocks_on, ex);
         for (i = 0; i < 6; i++) begin
            port_access_valid <= 1;
            port_access_index <= i[2:0];
            @(posedge pclk) port_access_valid <= 0;
            @(posedge pclk) chk("fault", port_bus_fault, i > 4 || !ex[i % 5]);
         end
         apb(0, 12'h200, 32'h0, {2'h2, 30'h0, m[1:0]});
         if (m == 0) apb(0, 12'h060, 32'h0, {2'h2, 4'h0, k[0], 27'h0});
      end
      // Reset in mid-run must clear the written sleep set and stop every clock
      presetn <= 0;
      @(posedge pclk) presetn <= 1;
      @(posedge pclk);
      chk("reset", clocks_on, 5'h00);
      apb(0, 12'h118, 32'h0, {2'h2, 32'h0});
      conclude;
   end
endmodule : tb
